// ==== rtl/ivpu_defs.svh ====
`ifndef IVPU_DEFS_SVH
`define IVPU_DEFS_SVH

// ----------------------------------------------------------------------------
// Vector bases and trap vectors
// ----------------------------------------------------------------------------
`define IVPU_VEC_BASE      16'h2000
`define IVPU_PTS_BASE      16'h2040
`define IVPU_VEC_UNIMPL    16'h2012
`define IVPU_VEC_SWTRAP    16'h2010
`define IVPU_VEC_UPPER_GAP 16'h0020

// ----------------------------------------------------------------------------
// Priorities
// ----------------------------------------------------------------------------
`define IVPU_PRIO_TOP      5'h1E
`define IVPU_PRIO_BOTTOM   5'h00
`define IVPU_PTS_PRIO_OFS  5'h0F

// ----------------------------------------------------------------------------
// Slot numbers (slot number is also the ordinary priority, except NMI slot 15 at 30)
// ----------------------------------------------------------------------------
`define IVPU_SLOT_NMI      4'hF
`define IVPU_SLOT_EXT      4'hE
`define IVPU_SLOT_RSVD     4'hD
`define IVPU_SLOT_URX      4'hC
`define IVPU_SLOT_UTX      4'hB
`define IVPU_SLOT_SP1      4'hA
`define IVPU_SLOT_SP0      4'h9
`define IVPU_SLOT_VB_ST    4'h8
`define IVPU_SLOT_VB_RX    4'h7
`define IVPU_SLOT_VB_TX    4'h6
`define IVPU_SLOT_ADC      4'h5
`define IVPU_SLOT_CC0      4'h4
`define IVPU_SLOT_CC1      4'h3
`define IVPU_SLOT_CC2      4'h2
`define IVPU_SLOT_CC3      4'h1
`define IVPU_SLOT_SHARED   4'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IVPU_PEND_RST      16'h0000
`define IVPU_SEL_RST       16'h0000

`endif

// ==== rtl/ivpu_pkg.sv ====
package ivpu_pkg;
  // Slot index 0..15
  typedef logic [3:0]  ivpu_slot_t;
  // Priority level 0..30
  typedef logic [4:0]  ivpu_prio_t;
  // Vector address
  typedef logic [15:0] ivpu_addr_t;
  // Kind of service delivered to the core
  typedef enum logic [1:0] {IVPU_KIND_IRQ, IVPU_KIND_PTS, IVPU_KIND_TRAP} ivpu_kind_t;
endpackage

// ==== rtl/ivpu_ea_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Event array link between arbiter and shared-source array
// ----------------------------------------------------------------------------
interface ivpu_ea_if #(parameter int EA_N = 14);
  logic                    shared_irq;  // Any enabled merged source pending
  logic [3:0]              prio_idx;    // Highest pending merged source
  logic [EA_N-1:0]         pend;        // Merged pending bits
  logic                    clr;         // Clear strobe from software side
  logic [3:0]              clr_idx;     // Index to clear
  modport arr  (output shared_irq, output prio_idx, output pend, input clr, input clr_idx);
  modport core (input shared_irq, input prio_idx, input pend, output clr, output clr_idx);
endinterface
`default_nettype wire

// ==== rtl/ivpu_event_array.sv ====
`timescale 1ns/1ps
`default_nettype none
module ivpu_event_array #(
  parameter int EA_N = 14
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Merged sources
  input  wire logic [EA_N-1:0] events,
  input  wire logic [EA_N-1:0] mask,
  // Link to arbiter
  ivpu_ea_if.arr           ea
);
  import ivpu_pkg::*;

  // Refuse sizes that the 4-bit index cannot serve
  if (EA_N < 1 || EA_N > 16) begin
    $error("EA_N must be 1..16");
  end

  logic [EA_N-1:0] pend_r;    // Merged pending bits
  logic [EA_N-1:0] pend_nxt;  // Next pending bits
  logic [3:0]      prio_r;    // Registered winner index
  logic [3:0]      prio_nxt;  // Next winner index

  // ----------------------------------------------------------------------------
  // Pending bits and sub-priority
  // ----------------------------------------------------------------------------
  // Clear first, then set, so a new event wins over a clear
  always_comb begin
    pend_nxt = pend_r;
    if (ea.clr && ea.clr_idx < EA_N) begin
      pend_nxt[ea.clr_idx] = 1'b0;
    end
    pend_nxt = pend_nxt | events;
    prio_nxt = 4'h0;
    // Higher index wins among the merged sources
    for (int i = 0; i < EA_N; i++) begin
      if (pend_r[i] && mask[i]) begin
        prio_nxt = 4'(i);
      end
    end
  end

  // Register state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= '0;
      prio_r <= 4'h0;
    end else begin
      pend_r <= pend_nxt;
      prio_r <= prio_nxt;
    end
  end

  // Merge enabled sources into one request
  assign ea.shared_irq = |(pend_r & mask);
  assign ea.prio_idx   = prio_r;
  assign ea.pend       = pend_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_ea_event_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (|events) |=> ((pend_r & $past(events)) == $past(events)))
    else $error("merged event lost");
endmodule
`default_nettype wire

// ==== rtl/ivpu_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Traps go first; then larger priority number wins, 30 to 0
// - External pin 203C, async receive 2038; 205C/2058
// - Capture channels 2008 down to 2002; 2048 down to 2042
// - Nonmaskable 203E, priority 30, no microcoded
// - Sync port 1: 2034 at 10, 2054 at 25
// - Sync port 0: 2032 at 9, 2052 at 24
// - Vehicle bus status 2030/2050, else reserved
// - Vehicle bus receive 200E/204E, else reserved
// - Vehicle bus transmit 200C/204C, else reserved
// - Converter done 200A/204A, else reserved
// - Many timer events merge into 2000/2040
// - Merged sources ordered by own sub-priority
// - Former slave port slots serve vehicle bus
// - Pending set on request, cleared when taken
// - Mask bit and global enable gate maskable
// - Select bit picks microcoded vector; count zero clears
`include "ivpu_defs.svh"
module ivpu_top #(
  parameter bit HAS_VEHICLE_BUS = 1'b1,
  parameter bit HAS_ADC         = 1'b1,
  parameter int EA_N            = 14
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Pins
  input  wire logic                 nmi_pin,
  input  wire logic                 external_pin_irq,
  // On-chip request pulses
  input  wire logic                 uart_rx_event,
  input  wire logic                 uart_tx_event,
  input  wire logic                 sync_port1_done,
  input  wire logic                 sync_port0_done,
  input  wire logic                 vehicle_bus_status_irq,
  input  wire logic                 vehicle_bus_receive_irq,
  input  wire logic                 vehicle_bus_transmit_irq,
  input  wire logic                 adc_done_irq,
  input  wire logic                 capture_compare_ch0_irq,
  input  wire logic                 capture_compare_ch1_irq,
  input  wire logic                 capture_compare_ch2_irq,
  input  wire logic                 capture_compare_ch3_irq,
  input  wire logic [EA_N-1:0]      event_array_events,
  input  wire logic [EA_N-1:0]      event_array_mask,
  input  wire logic                 event_array_clear,
  input  wire logic [3:0]           event_array_clear_idx,
  // Traps from the core
  input  wire logic                 trap_unimpl,
  input  wire logic                 trap_sw,
  // Mask, enable and service select
  input  wire logic [15:0]          irq_mask,
  input  wire logic                 global_enable,
  input  wire logic                 select_load,
  input  wire logic [15:0]          select_wdata,
  input  wire logic                 transfer_count_zero,
  // Vector handshake to the core
  output logic                      vec_valid,
  output ivpu_pkg::ivpu_addr_t      vec_addr,
  output ivpu_pkg::ivpu_prio_t      vec_prio,
  output ivpu_pkg::ivpu_kind_t      vec_kind,
  output ivpu_pkg::ivpu_slot_t      vec_slot,
  input  wire logic                 vec_ack,
  // State readback
  output logic [15:0]               irq_pending,
  output logic [15:0]               microcoded_service_select,
  output logic [7:0]                event_array_pending_lo,
  output logic [7:0]                event_array_pending_hi,
  output logic [3:0]                event_array_priority_vector
);
  import ivpu_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  localparam logic [15:0] RSVD_MASK = 16'h2000
    | (HAS_VEHICLE_BUS ? 16'h0000 : 16'h01C0)
    | (HAS_ADC ? 16'h0000 : 16'h0020);       // Slots that never raise
  localparam logic [15:0] SEL_VALID = 16'h7FFF & ~RSVD_MASK;  // No microcoded NMI

  logic [1:0]  nmi_sync_r;      // Pin synchroniser
  logic [1:0]  ext_sync_r;      // Pin synchroniser
  logic        nmi_prev_r;      // Edge history
  logic        ext_prev_r;      // Edge history
  logic [15:0] pend_r;          // Pending bits
  logic [15:0] pend_nxt;
  logic [15:0] sel_r;           // Microcoded service select
  logic [15:0] sel_nxt;
  logic [1:0]  trap_r;          // Trap pending: [1] unimpl, [0] software
  logic [1:0]  trap_nxt;
  logic        valid_r;         // Vector output state
  logic        valid_nxt;
  ivpu_addr_t  addr_r;
  ivpu_addr_t  addr_nxt;
  ivpu_prio_t  prio_r;
  ivpu_prio_t  prio_nxt;
  ivpu_kind_t  kind_r;
  ivpu_kind_t  kind_nxt;
  ivpu_slot_t  slot_r;
  ivpu_slot_t  slot_nxt;
  ivpu_slot_t  last_pts_r;      // Slot of last microcoded service
  ivpu_slot_t  last_pts_nxt;
  logic [15:0] raw_req;         // Request pulses per slot
  logic [15:0] eligible;        // Pending and enabled
  logic [EA_N-1:0] ea_pend16;

  ivpu_ea_if #(.EA_N(EA_N)) ea ();

  // Refuse sizes that the two readback bytes cannot serve
  if (EA_N < 9 || EA_N > 16) begin
    $error("EA_N must be 9..16");
  end

  // ----------------------------------------------------------------------------
  // Shared event array
  // ----------------------------------------------------------------------------
  ivpu_event_array #(.EA_N(EA_N)) u_ea (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .events  (event_array_events),
    .mask    (event_array_mask),
    .ea      (ea.arr)
  );
  // Software clears a merged source after reading the pending words
  assign ea.clr     = event_array_clear;
  assign ea.clr_idx = event_array_clear_idx;
  assign ea_pend16  = ea.pend;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      nmi_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      nmi_sync_r <= {nmi_sync_r[0], nmi_pin};
      ext_sync_r <= {ext_sync_r[0], external_pin_irq};
      nmi_prev_r <= nmi_sync_r[1];
      ext_prev_r <= ext_sync_r[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Request map
  // ----------------------------------------------------------------------------
  // Old slave port slots 8..6 now carry the vehicle bus sources
  always_comb begin
    raw_req                   = 16'h0000;
    raw_req[`IVPU_SLOT_NMI]   = nmi_sync_r[1] && !nmi_prev_r;
    raw_req[`IVPU_SLOT_EXT]   = ext_sync_r[1] && !ext_prev_r;
    raw_req[`IVPU_SLOT_URX]   = uart_rx_event;
    raw_req[`IVPU_SLOT_UTX]   = uart_tx_event;
    raw_req[`IVPU_SLOT_SP1]   = sync_port1_done;
    raw_req[`IVPU_SLOT_SP0]   = sync_port0_done;
    raw_req[`IVPU_SLOT_VB_ST] = vehicle_bus_status_irq;
    raw_req[`IVPU_SLOT_VB_RX] = vehicle_bus_receive_irq;
    raw_req[`IVPU_SLOT_VB_TX] = vehicle_bus_transmit_irq;
    raw_req[`IVPU_SLOT_ADC]   = adc_done_irq;
    raw_req[`IVPU_SLOT_CC0]   = capture_compare_ch0_irq;
    raw_req[`IVPU_SLOT_CC1]   = capture_compare_ch1_irq;
    raw_req[`IVPU_SLOT_CC2]   = capture_compare_ch2_irq;
    raw_req[`IVPU_SLOT_CC3]   = capture_compare_ch3_irq;
    raw_req[`IVPU_SLOT_SHARED] = ea.shared_irq;
    // Reserved slots on smaller variants stay silent
    raw_req = raw_req & ~RSVD_MASK;
  end

  // ----------------------------------------------------------------------------
  // Arbitration and pending update
  // ----------------------------------------------------------------------------
  always_comb begin
    pend_nxt     = pend_r;
    sel_nxt      = sel_r;
    trap_nxt     = trap_r;
    last_pts_nxt = last_pts_r;
    valid_nxt    = 1'b0;
    addr_nxt     = addr_r;
    prio_nxt     = prio_r;
    kind_nxt     = kind_r;
    slot_nxt     = slot_r;
    // Taking a vector clears its pending bit
    if (vec_ack && valid_r) begin
      if (kind_r == IVPU_KIND_TRAP) begin
        trap_nxt[slot_r[0]] = 1'b0;
      end else begin
        pend_nxt[slot_r] = 1'b0;
        if (kind_r == IVPU_KIND_PTS) begin
          last_pts_nxt = slot_r;
        end
      end
    end
    // New requests win over the clear
    pend_nxt = pend_nxt | raw_req;
    trap_nxt = trap_nxt | {trap_unimpl, trap_sw};
    // Count reaching zero ends microcoded service of that slot
    if (transfer_count_zero) begin
      sel_nxt[last_pts_r] = 1'b0;
    end
    if (select_load) begin
      sel_nxt = select_wdata & SEL_VALID;
    end
    // Traps are instruction synchronous and go ahead of all levels
    if (trap_r != 2'h0) begin
      valid_nxt = !vec_ack;
      kind_nxt  = IVPU_KIND_TRAP;
      prio_nxt  = `IVPU_PRIO_BOTTOM;
      slot_nxt  = trap_r[1] ? 4'h1 : 4'h0;
      addr_nxt  = trap_r[1] ? `IVPU_VEC_UNIMPL : `IVPU_VEC_SWTRAP;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (eligible[i]) begin
          // Ascending scan: later higher levels override
          valid_nxt = !vec_ack;
          slot_nxt  = 4'(i);
          if (sel_r[i]) begin
            kind_nxt = IVPU_KIND_PTS;
            prio_nxt = 5'(i) + `IVPU_PTS_PRIO_OFS;
            addr_nxt = `IVPU_PTS_BASE + 16'(2 * i);
          end else begin
            kind_nxt = IVPU_KIND_IRQ;
            prio_nxt = 5'(i);
            // Slots 8 and up sit above the trap vectors
            addr_nxt = `IVPU_VEC_BASE + 16'(2 * i) + (i >= 8 ? `IVPU_VEC_UPPER_GAP : 16'h0000);
          end
          if (i == 15) begin
            prio_nxt = `IVPU_PRIO_TOP;
          end
        end
      end
    end
  end

  // Maskable slots need their mask bit and the global enable
  always_comb begin
    eligible = pend_r & irq_mask & {16{global_enable}};
    eligible[`IVPU_SLOT_NMI] = pend_r[`IVPU_SLOT_NMI];
    // Arbitrate by level: microcoded slots sit above every ordinary one except nonmaskable slot 15
    if ((eligible & sel_r) != 16'h0000) begin
      eligible = eligible & (sel_r | 16'h8000);
    end
  end

  // Register state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r     <= `IVPU_PEND_RST;
      sel_r      <= `IVPU_SEL_RST;
      trap_r     <= 2'h0;
      last_pts_r <= 4'h0;
      valid_r    <= 1'b0;
      addr_r     <= 16'h0000;
      prio_r     <= 5'h00;
      kind_r     <= IVPU_KIND_IRQ;
      slot_r     <= 4'h0;
    end else begin
      pend_r     <= pend_nxt;
      sel_r      <= sel_nxt;
      trap_r     <= trap_nxt;
      last_pts_r <= last_pts_nxt;
      valid_r    <= valid_nxt;
      addr_r     <= addr_nxt;
      prio_r     <= prio_nxt;
      kind_r     <= kind_nxt;
      slot_r     <= slot_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign vec_valid                   = valid_r;
  assign vec_addr                    = addr_r;
  assign vec_prio                    = prio_r;
  assign vec_kind                    = kind_r;
  assign vec_slot                    = slot_r;
  assign irq_pending                 = pend_r;
  assign microcoded_service_select   = sel_r;
  assign event_array_pending_lo      = ea_pend16[7:0];
  assign event_array_pending_hi      = 8'(ea_pend16[EA_N-1:8]);
  assign event_array_priority_vector = ea.prio_idx;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_nmi_vector_prio: assert property (valid_r && slot_r == 4'hF && kind_r != IVPU_KIND_TRAP
    |-> addr_r == 16'h203E && prio_r == 5'd30 && kind_r == IVPU_KIND_IRQ)
    else $error("nonmaskable vector wrong");
  a_irq_vector_map: assert property (valid_r && kind_r == IVPU_KIND_IRQ
    |-> addr_r == 16'h2000 + 16'(2 * slot_r) + (slot_r[3] ? 16'h0020 : 16'h0000)
    && (slot_r == 4'hF || prio_r == 5'(slot_r)))
    else $error("ordinary vector map wrong");
  a_pts_vector_map: assert property (valid_r && kind_r == IVPU_KIND_PTS
    |-> addr_r == 16'h2040 + 16'(2 * slot_r) && prio_r == 5'(slot_r) + 5'd15)
    else $error("microcoded vector map wrong");
  a_trap_vectors: assert property (valid_r && kind_r == IVPU_KIND_TRAP
    |-> addr_r == 16'h2010 || addr_r == 16'h2012)
    else $error("trap vector wrong");
  a_mask_gates: assert property (valid_r && kind_r != IVPU_KIND_TRAP && slot_r != 4'hF
    |-> $past(irq_mask[slot_r]) && $past(global_enable))
    else $error("masked request served");
  a_pend_cleared: assert property (vec_ack && valid_r && kind_r != IVPU_KIND_TRAP && !raw_req[slot_r]
    |=> !pend_r[$past(slot_r)])
    else $error("pending not cleared on take");
  a_ext_pin_latency: assert property ($rose(external_pin_irq)
    |=> ##2 pend_r[14])
    else $error("pin request not pending");
  a_no_reserved: assert property (!pend_r[13])
    else $error("reserved slot pending");
  a_lower_waits: assert property (valid_r && vec_ack
    |=> ((pend_r | (16'h0001 << $past(slot_r))) & $past(pend_r)) == $past(pend_r))
    else $error("lower request dropped");
  a_sel_count_zero: assert property (transfer_count_zero && !select_load
    |=> !sel_r[$past(last_pts_r)])
    else $error("select bit not cleared");
endmodule
`default_nettype wire

// ==== test/ivpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Core side: takes each offered vector after a set wait
// ----------------------------------------------------------------------------
module ivpu_core_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Vector offer from the unit
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  input  wire logic [3:0]  ack_wait,
  // Acknowledge and record of what was taken
  output logic             vec_ack,
  output logic [15:0]      taken_addr,
  output logic [7:0]       taken_n
);
  logic [3:0] wait_r;  // Cycles the offer has stood

  // One ack per offer, only while the offer stands
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_ack    <= 1'b0;
      wait_r     <= 4'h0;
      taken_addr <= 16'h0000;
      taken_n    <= 8'h00;
    end else begin
      // Every handler, the nonmaskable one too, returns at once
      vec_ack <= vec_valid && !vec_ack && (wait_r >= ack_wait);
      wait_r  <= (vec_valid && !vec_ack) ? wait_r + 4'h1 : 4'h0;
      // Vector is taken at the edge that sees the ack
      if (vec_ack && vec_valid) begin
        taken_addr <= vec_addr;
        taken_n    <= taken_n + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Bench for the vector and priority unit
// ----------------------------------------------------------------------------
module tb;
  import ivpu_pkg::*;
  // One source case: slot, select bit, expected vector and level
  typedef struct packed {logic [3:0] slot; logic sel; logic [15:0] addr; logic [4:0] prio;} ivpu_row_t;
  logic        sys_clk  = 1'b0;      // 250 MHz clock
  logic        reset_n  = 1'b0;      // Async reset
  logic [15:0] req      = 16'h0000;  // Request per slot
  logic [13:0] ea_ev    = 14'h0000;  // Merged events
  logic        ea_clr   = 1'b0;      // Merged clear strobe
  logic [3:0]  ea_idx   = 4'h0;      // Merged clear index
  logic        t_un     = 1'b0;      // Unimplemented opcode trap
  logic        t_sw     = 1'b0;      // Software trap
  logic [15:0] mask     = 16'hFFFF;  // Per-slot enables
  logic        g_en     = 1'b1;      // Global enable
  logic        sel_ld   = 1'b0;      // Select load strobe
  logic [15:0] sel_wd   = 16'h0000;  // Select data
  logic        cnt_zero = 1'b0;      // Transfer count ran out
  logic [3:0]  ack_wait = 4'h2;      // Core response delay
  logic        vec_valid, vec_ack;   // Vector handshake
  ivpu_addr_t  vec_addr;             // Offered vector
  ivpu_prio_t  vec_prio;             // Offered level
  ivpu_kind_t  vec_kind;             // Offered service kind
  ivpu_slot_t  vec_slot;             // Offered slot
  logic [15:0] pend, msel, taken_addr;
  logic [7:0]  ea_lo, ea_hi, taken_n;
  logic [3:0]  ea_pv;                // Top merged source
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  ivpu_row_t   rows [25] = '{
    '{4'hF, 1'h0, 16'h203E, 5'h1E}, '{4'hF, 1'h1, 16'h203E, 5'h1E}, '{4'hE, 1'h0, 16'h203C, 5'h0E},
    '{4'hE, 1'h1, 16'h205C, 5'h1D}, '{4'hC, 1'h0, 16'h2038, 5'h0C}, '{4'hC, 1'h1, 16'h2058, 5'h1B},
    '{4'hA, 1'h0, 16'h2034, 5'h0A}, '{4'hA, 1'h1, 16'h2054, 5'h19}, '{4'h9, 1'h0, 16'h2032, 5'h09},
    '{4'h9, 1'h1, 16'h2052, 5'h18}, '{4'h8, 1'h0, 16'h2030, 5'h08}, '{4'h8, 1'h1, 16'h2050, 5'h17},
    '{4'h7, 1'h0, 16'h200E, 5'h07}, '{4'h7, 1'h1, 16'h204E, 5'h16}, '{4'h6, 1'h0, 16'h200C, 5'h06},
    '{4'h6, 1'h1, 16'h204C, 5'h15}, '{4'h5, 1'h0, 16'h200A, 5'h05}, '{4'h5, 1'h1, 16'h204A, 5'h14},
    '{4'h4, 1'h0, 16'h2008, 5'h04}, '{4'h4, 1'h1, 16'h2048, 5'h13}, '{4'h3, 1'h0, 16'h2006, 5'h03},
    '{4'h2, 1'h0, 16'h2004, 5'h02}, '{4'h1, 1'h0, 16'h2002, 5'h01}, '{4'h0, 1'h0, 16'h2000, 5'h00},
    '{4'h0, 1'h1, 16'h2040, 5'h0F}};

  ivpu_top ivpu_top_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .nmi_pin(req[15]), .external_pin_irq(req[14]),
    .uart_rx_event(req[12]), .uart_tx_event(req[11]), .sync_port1_done(req[10]), .sync_port0_done(req[9]),
    .vehicle_bus_status_irq(req[8]), .vehicle_bus_receive_irq(req[7]), .vehicle_bus_transmit_irq(req[6]),
    .adc_done_irq(req[5]), .capture_compare_ch0_irq(req[4]), .capture_compare_ch1_irq(req[3]),
    .capture_compare_ch2_irq(req[2]), .capture_compare_ch3_irq(req[1]), .event_array_events(ea_ev),
    .event_array_mask(14'h3FFF), .event_array_clear(ea_clr), .event_array_clear_idx(ea_idx),
    .trap_unimpl(t_un), .trap_sw(t_sw), .irq_mask(mask), .global_enable(g_en), .select_load(sel_ld),
    .select_wdata(sel_wd), .transfer_count_zero(cnt_zero), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .vec_prio(vec_prio), .vec_kind(vec_kind), .vec_slot(vec_slot), .vec_ack(vec_ack), .irq_pending(pend),
    .microcoded_service_select(msel), .event_array_pending_lo(ea_lo), .event_array_pending_hi(ea_hi),
    .event_array_priority_vector(ea_pv));

  ivpu_core_model ivpu_core_model_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .ack_wait(ack_wait), .vec_ack(vec_ack), .taken_addr(taken_addr), .taken_n(taken_n));

  // Clock and hang guard
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle request on the slots in m; slot 0 goes through merged event 0
  task automatic pulse(input logic [15:0] m);
    req   = m;
    ea_ev = {13'h0000, m[0]};
    tick(1);
    req   = 16'h0000;
    ea_ev = 14'h0000;
  endtask

  task automatic load_sel(input logic [15:0] v);
    sel_wd = v;
    sel_ld = 1'b1;
    tick(1);
    sel_ld = 1'b0;
  endtask

  // Bounded wait for an offer
  task automatic wait_valid();
    int i;
    i = 0;
    while (vec_valid !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    check("vec_valid", {15'h0000, vec_valid}, 16'h0001);
  endtask

  // Bounded wait for the core to take the next vector
  task automatic take(input logic [15:0] exp);
    logic [7:0] n0;
    int i;
    n0 = taken_n;
    i  = 0;
    while (taken_n === n0 && i < 40) begin
      tick(1);
      i++;
    end
    check("taken_n", 16'(taken_n - n0), 16'h0001);
    check("taken_addr", taken_addr, exp);
  endtask

  task automatic clear_ea(input logic [3:0] k);
    ea_clr = 1'b1;
    ea_idx = k;
    tick(1);
    ea_clr = 1'b0;
    tick(10);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(5);
    check("pending", pend, 16'h0000);
    check("select", msel, 16'h0000);
    reset_n = 1'b1;
    tick(1);
    // Every source but slot 11 ordinary; microcoded for all but slots 11, 3..1 and nonmaskable slot 15
    for (int r = 0; r < 25; r++) begin
      load_sel(rows[r].sel ? (16'h0001 << rows[r].slot) : 16'h0000);
      pulse(16'h0001 << rows[r].slot);
      wait_valid();
      check("vec_addr", vec_addr, rows[r].addr);
      check("vec_prio", 16'(vec_prio), 16'(rows[r].prio));
      check("vec_kind", 16'(vec_kind), {15'h0000, rows[r].sel && rows[r].slot != 4'hF});
      check("vec_slot", 16'(vec_slot), 16'(rows[r].slot));
      take(rows[r].addr);
      if (rows[r].slot != 4'h0)
        check("pending", pend[rows[r].slot], 1'b0);
      else
        clear_ea(4'h0);
    end
    // Two levels at once: higher first, lower waits
    pulse(16'h0402);
    wait_valid();
    check("pending", pend[1], 1'b1);
    take(16'h2034);
    take(16'h2002);
    // Masked and globally disabled requests wait; nonmaskable does not
    mask = 16'hF7FF;
    pulse(16'h0800);
    tick(6);
    check("vec_valid", vec_valid, 1'b0);
    check("pending", pend[11], 1'b1);
    g_en = 1'b0;
    mask = 16'h0000;
    pulse(16'h8000);
    take(16'h203E);
    mask = 16'hFFFF;
    tick(6);
    check("vec_valid", vec_valid, 1'b0);
    g_en = 1'b1;
    take(16'h2036);
    // Both traps together with a receive request
    t_un = 1'b1;
    t_sw = 1'b1;
    pulse(16'h1000);
    t_un = 1'b0;
    t_sw = 1'b0;
    wait_valid();
    check("vec_kind", 16'(vec_kind), 16'h0002);
    take(16'h2012);
    take(16'h2010);
    take(16'h2038);
    // Select bits that do not exist stay clear; count end drops a channel
    load_sel(16'hFFFF);
    check("select", msel, 16'h5FFF);
    load_sel(16'h0010);
    pulse(16'h0010);
    take(16'h2048);
    cnt_zero = 1'b1;
    tick(1);
    cnt_zero = 1'b0;
    tick(1);
    check("select", msel, 16'h0000);
    pulse(16'h0010);
    take(16'h2008);
    // Two merged sources share one vector, ordered among themselves
    ea_ev = 14'h0208;
    tick(1);
    ea_ev = 14'h0000;
    wait_valid();
    check("ea_pv", 16'(ea_pv), 16'h0009);
    check("ea_pend", {ea_hi, ea_lo}, 16'h0208);
    take(16'h2000);
    clear_ea(4'h9);
    check("ea_pv", 16'(ea_pv), 16'h0003);
    clear_ea(4'h3);
    complete_run();
  end
endmodule
`default_nettype wire
